// *** core/lce_channel_irq.sv ***
/*
 * Per-channel LIU interrupt enable and gating. Holds the enable register,
 * shows the current status levels and the sticky change flags, and raises
 * one channel interrupt request.
 * Per-channel map, channel id in the top address nibble:
 *   f04 enable, read/write, bit 7 reads zero
 *   f05 status levels, read-only, one cycle behind the inputs
 *   f06 change flags, read-only, cleared by the read that returns them
 * Assumes a synchronous byte-wide host register port with one-cycle
 * strobes; status levels come from the transmit and receive LIU sections
 * on the same clock. The LIU and framer are expected to run single-rail,
 * and software turns to the framer's own enables when the framer is in path.
 * A status input that is already high at reset release counts as a rise.
 */
module lce_channel_irq
    import lce_pkg::*;
#(
    parameter logic [3:0] CHANNEL_ID = 4'h0
)
(
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    input wire logic [15:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    input wire logic driver_monitor_status_i,
    input wire logic fifo_limit_i,
    input wire logic line_violation_i,
    input wire logic loop_code_detect_i,
    input wire logic alarm_signal_i,
    input wire logic receive_signal_loss_i,
    input wire logic pattern_detect_i,
    output logic irq_o
);

    logic [6:0] liu_channel_irq_enable;
    logic [6:0] next_enable;
    logic [7:0] rdata_q;
    logic [7:0] next_rdata;
    logic irq_q;
    logic next_irq;
    logic [6:0] src_level;
    logic [6:0] seen_level;
    logic [6:0] change_flag;
    logic [6:0] change_clear;
    logic chan_hit;
    logic sel_enable;
    logic sel_status;
    logic sel_change;

    // Enable fields, named for readability
    logic driver_fault_change_irq_en;
    logic fifo_limit_irq_en;
    logic line_violation_irq_en;
    logic loop_code_change_irq_en;
    logic alarm_signal_irq_en;
    logic signal_loss_change_irq_en;
    logic pattern_detect_change_irq_en;

    assign driver_fault_change_irq_en = liu_channel_irq_enable[LCE_BIT_DRIVER];
    assign fifo_limit_irq_en = liu_channel_irq_enable[LCE_BIT_FIFO_LIMIT];
    assign line_violation_irq_en = liu_channel_irq_enable[LCE_BIT_LINE_VIOL];
    assign loop_code_change_irq_en = liu_channel_irq_enable[LCE_BIT_LOOP_CODE];
    assign alarm_signal_irq_en = liu_channel_irq_enable[LCE_BIT_ALARM];
    assign signal_loss_change_irq_en = liu_channel_irq_enable[LCE_BIT_SIGNAL_LOSS];
    assign pattern_detect_change_irq_en = liu_channel_irq_enable[LCE_BIT_PATTERN];

    // ==========================================================
    // Address decode
    assign chan_hit = (reg_addr_i[15:12] == CHANNEL_ID);
    assign sel_enable = chan_hit && (reg_addr_i[11:0] == LCE_ADDR_ENABLE);
    assign sel_status = chan_hit && (reg_addr_i[11:0] == LCE_ADDR_STATUS);
    assign sel_change = chan_hit && (reg_addr_i[11:0] == LCE_ADDR_CHANGE);
    // Status and change registers have no write path; such writes are dropped

    // ==========================================================
    // Status sources
    // Bit 7 has no source and reads zero in every register
    always_comb
    begin
        src_level = '0;
        src_level[LCE_BIT_DRIVER] = driver_monitor_status_i;
        src_level[LCE_BIT_FIFO_LIMIT] = fifo_limit_i;
        src_level[LCE_BIT_LINE_VIOL] = line_violation_i;
        src_level[LCE_BIT_LOOP_CODE] = loop_code_detect_i;
        src_level[LCE_BIT_ALARM] = alarm_signal_i;
        src_level[LCE_BIT_SIGNAL_LOSS] = receive_signal_loss_i;
        src_level[LCE_BIT_PATTERN] = pattern_detect_i;
    end

    // Reading the change register clears the flags it returned
    // An event in the read cycle is kept, since the cell lets a set win over a clear
    assign change_clear = (reg_rd_i && sel_change) ? change_flag : '0;

    // Per-source change detection, edge policy per bit
    // Fifo limit, line violation and alarm flag on the rising edge only
    genvar gi;
    generate
        for (gi = 0; gi < LCE_NUM_SRC; gi++)
        begin : g_src
            lce_evt_cell #(
                .BOTH_EDGES(LCE_BOTH_EDGE_MASK[gi])
            ) u_cell (
                .clk_sys_i(clk_sys_i),
                .rstn_i(rstn_i),
                .level_i(src_level[gi]),
                .clear_i(change_clear[gi]),
                .flag_o(change_flag[gi]),
                .level_o(seen_level[gi])
            );
        end
    endgenerate

    // ==========================================================
    // Enable register
    always_comb
    begin
        next_enable = liu_channel_irq_enable;
        if (reg_wr_i && sel_enable)
        begin
            next_enable = reg_wdata_i[6:0] & LCE_WRITABLE_MASK;
        end
    end

    // Bit 7 has no storage, so it always reads back as zero
    always_ff @(posedge clk_sys_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            liu_channel_irq_enable <= LCE_ENABLE_RST[6:0];
        end
        else
        begin
            liu_channel_irq_enable <= next_enable;
        end
    end

    // ==========================================================
    // Read data
    always_comb
    begin
        next_rdata = rdata_q;
        if (reg_rd_i)
        begin
            if (sel_enable)
            begin
                next_rdata = {1'b0, liu_channel_irq_enable};
            end
            else if (sel_status)
            begin
                next_rdata = {1'b0, seen_level};
            end
            else if (sel_change)
            begin
                next_rdata = {1'b0, change_flag};
            end
            else
            begin
                next_rdata = LCE_RDATA_RST;
            end
        end
    end

    // The read value stands until the next read strobe
    always_ff @(posedge clk_sys_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            rdata_q <= LCE_RDATA_RST;
        end
        else
        begin
            rdata_q <= next_rdata;
        end
    end

    // ==========================================================
    // Interrupt request
    always_comb
    begin
        next_irq = (change_flag[LCE_BIT_DRIVER] & driver_fault_change_irq_en)
            | (change_flag[LCE_BIT_FIFO_LIMIT] & fifo_limit_irq_en)
            | (change_flag[LCE_BIT_LINE_VIOL] & line_violation_irq_en)
            | (change_flag[LCE_BIT_LOOP_CODE] & loop_code_change_irq_en)
            | (change_flag[LCE_BIT_ALARM] & alarm_signal_irq_en)
            | (change_flag[LCE_BIT_SIGNAL_LOSS] & signal_loss_change_irq_en)
            | (change_flag[LCE_BIT_PATTERN] & pattern_detect_change_irq_en);
    end

    // Disabled sources still set flags, so a later enable raises the request;
    // it falls only once those flags are read or their enables are cleared
    always_ff @(posedge clk_sys_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            irq_q <= 1'b0;
        end
        else
        begin
            irq_q <= next_irq;
        end
    end

    // ==========================================================
    // Outputs
    assign reg_rdata_o = rdata_q;
    assign irq_o = irq_q;

endmodule

// *** core/lce_evt_cell.sv ***
/*
 * One status source: detects a change of its level (either edge, or a rise only when BOTH_EDGES is clear) and holds a sticky
 * change flag until software clears it.
 * Assumes the level input is synchronous to clk_sys_i.
 */
module lce_evt_cell
    import lce_pkg::*;
#(
    parameter bit BOTH_EDGES = 1'b1
)
(
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    input wire logic level_i,
    input wire logic clear_i,
    output logic flag_o,
    output logic level_o
);

    logic level_q;
    logic flag_q;
    logic next_level_q;
    logic next_flag_q;
    logic event_hit;

    // ==========================================================
    // Next state
    always_comb
    begin
        next_level_q = level_i;
        if (BOTH_EDGES)
        begin
            event_hit = level_i ^ level_q;
        end
        else
        begin
            event_hit = level_i & ~level_q;
        end
        // An edge detected in the clearing cycle keeps the flag set
        next_flag_q = event_hit | (flag_q & ~clear_i);
    end

    // ==========================================================
    // Registers
    always_ff @(posedge clk_sys_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            level_q <= 1'b0;
            flag_q <= 1'b0;
        end
        else
        begin
            level_q <= next_level_q;
            flag_q <= next_flag_q;
        end
    end

    assign flag_o = flag_q;
    assign level_o = level_q;

endmodule

// *** core/lce_pkg.sv ***
/*
 * Constants for the LIU channel interrupt enable block: register
 * addresses, field positions, reset values and the edge policy per source.
 * Assumes a byte-wide host register port with a 16-bit address whose top
 * nibble selects the channel.
 */
package lce_pkg;

    // ==========================================================
    // Register addresses (low twelve bits, channel in the top nibble)
    localparam logic [11:0] LCE_ADDR_ENABLE = 12'hf04;
    localparam logic [11:0] LCE_ADDR_STATUS = 12'hf05;
    localparam logic [11:0] LCE_ADDR_CHANGE = 12'hf06;

    // ==========================================================
    // Field positions, shared by enable, status and change registers
    localparam int LCE_NUM_SRC = 7;
    localparam int LCE_BIT_PATTERN = 0;
    localparam int LCE_BIT_SIGNAL_LOSS = 1;
    localparam int LCE_BIT_ALARM = 2;
    localparam int LCE_BIT_LOOP_CODE = 3;
    localparam int LCE_BIT_LINE_VIOL = 4;
    localparam int LCE_BIT_FIFO_LIMIT = 5;
    localparam int LCE_BIT_DRIVER = 6;
    localparam int LCE_BIT_UNUSED = 7;

    // ==========================================================
    // Reset values and the enable write mask
    localparam logic [7:0] LCE_ENABLE_RST = 8'h00;
    localparam logic [7:0] LCE_RDATA_RST = 8'h00;
    localparam logic [6:0] LCE_CHANGE_RST = 7'h00;
    localparam logic [6:0] LCE_WRITABLE_MASK = 7'h7f;

    // Sources that interrupt on both edges (set) or on the rising edge only (clear)
    localparam logic [6:0] LCE_BOTH_EDGE_MASK = 7'h4b;

endpackage

// *** tb/lce_channel_irq_props.sv ***
/* Port checks for the channel interrupt block.
   Bound onto lce_channel_irq; channel id sits in reg_addr_i[15:12]. */
module lce_channel_irq_props
    import lce_pkg::*;
#(
    parameter logic [3:0] CHANNEL_ID = 4'h0
)
(
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    input wire logic [15:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic driver_monitor_status_i,
    input wire logic fifo_limit_i,
    input wire logic line_violation_i,
    input wire logic loop_code_detect_i,
    input wire logic alarm_signal_i,
    input wire logic receive_signal_loss_i,
    input wire logic pattern_detect_i,
    input wire logic irq_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================
    // Shadow of the enable register
    logic [6:0] en;
    wire en_hit = reg_addr_i == {CHANNEL_ID, LCE_ADDR_ENABLE};
    always_ff @(posedge clk_sys_i or negedge rstn_i)
        if (!rstn_i)
            en <= 7'h00;
        else if (reg_wr_i && en_hit)
            en <= reg_wdata_i[6:0];
    // ==========================================
    // Properties
    default clocking @(posedge clk_sys_i);
    endclocking
    default disable iff (!rstn_i);
    property p_evt(logic on, logic ev);
        on && ev && !reg_rd_i |-> ##[1:2] irq_o;
    endproperty
    a_driver_both_edge: assert property (p_evt(en[6], $changed(driver_monitor_status_i)))
        else $error("driver change gave no irq");
    a_fifo_rise_irq: assert property (p_evt(en[5], $rose(fifo_limit_i)))
        else $error("fifo limit gave no irq");
    a_lcv_rise_irq: assert property (p_evt(en[4], $rose(line_violation_i)))
        else $error("line violation gave no irq");
    a_loop_both_edge: assert property (p_evt(en[3], $changed(loop_code_detect_i)))
        else $error("loop code change gave no irq");
    a_ais_rise_irq: assert property (p_evt(en[2], $rose(alarm_signal_i)))
        else $error("alarm signal gave no irq");
    a_los_both_edge: assert property (p_evt(en[1], $changed(receive_signal_loss_i)))
        else $error("signal loss change gave no irq");
    a_qrss_both_edge: assert property (p_evt(en[0], $changed(pattern_detect_i)))
        else $error("pattern change gave no irq");
    a_enable_read_back: assert property (reg_rd_i && en_hit |=> reg_rdata_o == {1'b0, $past(en)})
        else $error("enable readback wrong");
    a_irq_held_high: assert property (irq_o && !reg_rd_i && !$past(reg_rd_i) && !reg_wr_i && !$past(reg_wr_i) |=> irq_o)
        else $error("irq dropped without service");
    c_irq_rise: cover property ($rose(irq_o));
    c_irq_fall: cover property ($fell(irq_o));
    c_change_read: cover property (reg_rd_i && irq_o && reg_addr_i == {CHANNEL_ID, LCE_ADDR_CHANGE});
endmodule

// *** tb/tb_top.sv ***
/* Self-checking bench for lce_channel_irq with a bench model of flags.
   Assumes channel id 0 and the checker bound below. */
module tb_top
    import lce_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys_i = 1'b0, rstn_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0, irq_o;
    logic [15:0] reg_addr_i = 16'h0000;
    logic [7:0] reg_wdata_i = 8'h00, reg_rdata_o, rd_v;
    logic [6:0] src = 7'h00, m_en = 7'h00, m_flag = 7'h00;
    logic [31:0] seed = 32'h0000000c;
    int n_fail = 0, cmp_count = 0, cyc = 0;
    lce_channel_irq lce_channel_irq_inst (
        .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
        .driver_monitor_status_i(src[6]), .fifo_limit_i(src[5]), .line_violation_i(src[4]),
        .loop_code_detect_i(src[3]), .alarm_signal_i(src[2]), .receive_signal_loss_i(src[1]),
        .pattern_detect_i(src[0]), .irq_o(irq_o));
    initial
    begin
        forever #2.5 clk_sys_i = ~clk_sys_i;
    end
    always @(posedge clk_sys_i)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            n_fail++;
            close_out();
        end
    end
    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    task automatic close_out();
        if (n_fail == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
        cmp_count++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("Error at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask
    // One register access, then an idle cycle
    task automatic bus(input logic wr, input logic [15:0] a, input logic [7:0] d);
        reg_addr_i = a;
        reg_wdata_i = d;
        reg_wr_i = wr;
        reg_rd_i = !wr;
        @(posedge clk_sys_i);
        #1;
        rd_v = reg_rdata_o;
        reg_wr_i = 1'b0;
        reg_rd_i = 1'b0;
        if (wr && a == 16'h0f04)
            m_en = d[6:0];
        @(posedge clk_sys_i);
        #1;
    endtask
    task automatic set_src(input logic [6:0] v);
        m_flag = m_flag | ((v ^ src) & (LCE_BOTH_EDGE_MASK | v));
        src = v;
        repeat (3) @(posedge clk_sys_i);
        #1;
        chk({7'h00, irq_o}, {7'h00, |(m_flag & m_en)}, "irq after event");
    endtask
    task automatic drain();
        bus(1'b0, 16'h0f06, 8'h00);
        chk(rd_v, {1'b0, m_flag}, "change flags");
        m_flag = 7'h00;
        bus(1'b0, 16'h0f05, 8'h00);
        chk(rd_v, {1'b0, src}, "status levels");
        chk({7'h00, irq_o}, {7'h00, |(m_flag & m_en)}, "irq after service");
    endtask
    initial
    begin
        repeat (6) @(posedge clk_sys_i);
        #1;
        rstn_i = 1'b1;
        for (int i = 4; i < 8; i++)
        begin
            bus(1'b0, 16'h0f00 | i[15:0], 8'h00);
            chk(rd_v, 8'h00, "reset or unmapped read");
        end
        bus(1'b1, 16'h0f05, 8'hff);
        bus(1'b1, 16'h1f04, 8'hff);
        bus(1'b0, 16'h0f04, 8'h00);
        chk(rd_v, 8'h00, "foreign write");
        bus(1'b1, 16'h0f04, 8'hff);
        bus(1'b0, 16'h0f04, 8'h00);
        chk(rd_v, 8'h7f, "enable readback");
        for (int i = 0; i < 7; i++)
        begin
            bus(1'b1, 16'h0f04, 8'h01 << i);
            set_src(7'h01 << i);
            drain();
            set_src(7'h00);
            drain();
        end
        // Event and flag read land on one edge: the event is flagged after a read that returned no flags
        src = 7'h02;
        bus(1'b0, 16'h0f06, 8'h00);
        chk(rd_v, 8'h00, "flags before racing event");
        m_flag = 7'h02;
        drain();
        for (int k = 0; k < 40; k++)
        begin
            seed = xs(seed);
            set_src(seed[6:0]);
            seed = xs(seed);
            bus(1'b1, 16'h0f04, seed[7:0]);
            chk({7'h00, irq_o}, {7'h00, |(m_flag & m_en)}, "irq after enable change");
            if (seed[8])
                drain();
        end
        drain();
        close_out();
    end
endmodule
bind lce_channel_irq lce_channel_irq_props #(.CHANNEL_ID(CHANNEL_ID)) u_props (.clk_sys_i(clk_sys_i),
    .rstn_i(rstn_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .driver_monitor_status_i(driver_monitor_status_i),
    .fifo_limit_i(fifo_limit_i), .line_violation_i(line_violation_i), .loop_code_detect_i(loop_code_detect_i),
    .alarm_signal_i(alarm_signal_i), .receive_signal_loss_i(receive_signal_loss_i),
    .pattern_detect_i(pattern_detect_i), .irq_o(irq_o));
